// file: rtl/dmm_pkg.sv
package dmm_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Data space map
  localparam logic [15:0] IO_LAST = 16'h0FFF;
  localparam logic [15:0] EE_MAP_BASE = 16'h1000;
  localparam logic [15:0] SRAM_BASE = 16'h2000;
  localparam logic [15:0] SHORT_IO_LAST = 16'h003F;
  localparam logic [15:0] BIT_IO_LAST = 16'h001F;
  localparam logic [15:0] GPR_COUNT = 16'h0010;
  localparam logic [15:0] CLK_GRP_FIRST = 16'h0040;
  localparam logic [15:0] CLK_GRP_LAST = 16'h007F;
  localparam logic [15:0] EVT_GRP_FIRST = 16'h0180;
  localparam logic [15:0] EVT_GRP_LAST = 16'h01BF;
  localparam logic [15:0] WEX_GRP_FIRST = 16'h0980;
  localparam logic [15:0] WEX_GRP_LAST = 16'h09BF;
  localparam logic [15:0] ID_ADDR0 = 16'h0090;
  localparam logic [15:0] ID_ADDR1 = 16'h0091;
  localparam logic [15:0] ID_ADDR2 = 16'h0092;
  localparam logic [15:0] REV_ADDR = 16'h0093;

  ////////////////////////////////////////////////////////////////////////////
  // Access cycle counts
  localparam logic [2:0] IO_CYC = 3'h1;
  localparam logic [2:0] SRAM_WR_CYC = 3'h1;
  localparam logic [2:0] SRAM_RD_CYC = 3'h2;
  localparam logic [2:0] EE_LOAD_CYC = 3'h1;
  localparam logic [2:0] EE_RD_CYC = 3'h3;
  localparam logic [2:0] EE_BURST_CYC = 3'h2;
  localparam logic [2:0] RSVD_CYC = 3'h1;
  localparam logic [2:0] LAT_SHORT = 3'h1;
  localparam logic [2:0] LAT_OFFSET = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile page layout and lock bits
  localparam int EE_PAGE_BYTES = 32;
  localparam int EE_BYTE_W = 5;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] BIT_ONE = 8'h01;
  localparam int LOCK_W = 3;
  localparam int LOCK_CLK = 0;
  localparam int LOCK_EVT = 1;
  localparam int LOCK_WEX = 2;

  typedef enum logic [2:0] {
    KIND_LDST = 3'b000,
    KIND_SHORT_IO = 3'b001,
    KIND_SET_BIT = 3'b010,
    KIND_CLR_BIT = 3'b011,
    KIND_SKIP_SET = 3'b100,
    KIND_SKIP_CLR = 3'b101
  } dmm_kind_e;

  typedef enum logic [2:0] {
    NVM_NONE = 3'b000,
    NVM_RD_BYTE = 3'b001,
    NVM_LOAD_BUF = 3'b010,
    NVM_WR_BYTE = 3'b011,
    NVM_ER_BYTE = 3'b100,
    NVM_WR_PAGE = 3'b101,
    NVM_ER_PAGE = 3'b110
  } dmm_nvm_cmd_e;

  typedef enum logic [1:0] {
    RG_IO = 2'b00,
    RG_EE = 2'b01,
    RG_SRAM = 2'b10,
    RG_RSVD = 2'b11
  } dmm_region_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PAGE = 1'b1
  } dmm_nvm_state_e;

endpackage

// file: rtl/dmm_byte_mem.sv
`timescale 1ns/1ps
module dmm_byte_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);

  // Contents carry no reset; software never relies on power-up values
  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[raddr_i];

endmodule // dmm_byte_mem

// file: rtl/dmm_data_access.sv
// How it works
// - With mapping selected, EEPROM appears in data space from 0x1000.
// - After reset EEPROM stays in its own space until mapping is selected.
// - EEPROM write/erase works per page or per byte, reads per byte.
// - Short I/O instructions reach only I/O addresses 0x00 to 0x3F.
// - Single-cycle bit set, clear and skip reach only 0x00 to 0x1F.
// - The lowest 16 I/O addresses are plain storage with no side effect.
// - Every I/O register access finishes in one cycle.
// - SRAM writes take one cycle and SRAM reads return after two.
// - EEPROM buffer loads take one cycle and mapped reads take three.
// - Back-to-back mapped EEPROM reads give a byte every second cycle.
// - A three-byte identity and a revision byte are readable, not writable.
// - Writes to a locked clock, event or waveform group are dropped.
// - Lock bits change only during an open protection window.
// - The flash pointer splits into page number and word in page.
// - The EEPROM address splits into a 5-bit byte field and page above.
`timescale 1ns/1ps
module dmm_data_access
  import dmm_pkg::*;
#(
  parameter int SRAM_BYTES = 4096,
  parameter int EE_BYTES = 2048,
  parameter int FLASH_PAGE_WORDS = 256,
  parameter int FLASH_PTR_W = 24,
  parameter logic [7:0] ID_BYTE0 = 8'h5A, // Arbitrary value
  parameter logic [7:0] ID_BYTE1 = 8'h3C, // Arbitrary value
  parameter logic [7:0] ID_BYTE2 = 8'h11, // Arbitrary value
  parameter logic [7:0] REV_BYTE = 8'h01, // Arbitrary value
  localparam int EE_AW = $clog2(EE_BYTES),
  localparam int SRAM_AW = $clog2(SRAM_BYTES),
  localparam int FW = $clog2(FLASH_PAGE_WORDS),
  localparam int EP_W = EE_AW - EE_BYTE_W
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic acc_req_i,
  input wire logic acc_we_i,
  input wire dmm_kind_e acc_kind_i,
  input wire logic [ADDR_W-1:0] acc_addr_i,
  input wire logic [DATA_W-1:0] acc_wdata_i,
  input wire logic [2:0] acc_bit_i,
  output logic acc_ready_o,
  output logic acc_done_o,
  output logic [DATA_W-1:0] acc_rdata_o,
  output logic acc_skip_o,
  output logic acc_err_o,
  input wire logic ee_map_en_i,
  input wire logic [DATA_W-1:0] periph_rdata_i,
  output logic periph_we_o,
  output logic [ADDR_W-1:0] periph_addr_o,
  output logic [DATA_W-1:0] periph_wdata_o,
  output logic wr_blocked_o,
  input wire logic ccp_open_i,
  input wire logic lock_wr_i,
  input wire logic [LOCK_W-1:0] lock_wdata_i,
  output logic [LOCK_W-1:0] lock_o,
  input wire logic nvm_req_i,
  input wire dmm_nvm_cmd_e nvm_cmd_i,
  input wire logic [EE_AW-1:0] nvm_addr_i,
  input wire logic [DATA_W-1:0] nvm_wdata_i,
  output logic nvm_busy_o,
  output logic nvm_done_o,
  output logic [DATA_W-1:0] nvm_rdata_o,
  output logic [EE_BYTE_W-1:0] ee_byte_o,
  output logic [EP_W-1:0] ee_page_o,
  input wire logic [FLASH_PTR_W-1:0] flash_ptr_i,
  output logic [FW-1:0] flash_word_o,
  output logic [FLASH_PTR_W-FW-2:0] flash_page_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_span(input logic [15:0] a,
                                   input logic [15:0] base,
                                   input logic [15:0] span);
    logic [15:0] off;
    off = a - base;
    return (a >= base) && (off < span);
  endfunction

  function automatic dmm_region_e region_of(input logic [15:0] a,
                                            input logic map);
    dmm_region_e r;
    r = RG_RSVD;
    if (a <= IO_LAST) begin
      r = RG_IO;
    end else if (map && in_span(a, EE_MAP_BASE, 16'(EE_BYTES))) begin
      r = RG_EE;
    end else if (in_span(a, SRAM_BASE, 16'(SRAM_BYTES))) begin
      r = RG_SRAM;
    end
    return r;
  endfunction

  function automatic logic is_id(input logic [15:0] a);
    return in_range(a, ID_ADDR0, REV_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic map_q, ready_q, pend_q, done_q, skip_q, err_q, burst_q;
  logic [2:0] cnt_q;
  logic [DATA_W-1:0] rdata_q;
  logic [15:0] addr_q;
  dmm_region_e rg_q;
  logic [DATA_W-1:0] gpr_q [16];
  logic [LOCK_W-1:0] lock_q;
  logic pwe_q, blocked_q;
  logic [15:0] paddr_q;
  logic [DATA_W-1:0] pwdata_q;
  dmm_nvm_state_e st_q, st_d;
  logic [EE_BYTE_W-1:0] idx_q, ebyte_q;
  logic [EP_W-1:0] page_q, epage_q;
  logic erase_q, nbusy_q, ndone_q;
  logic [DATA_W-1:0] nrdata_q;
  logic [DATA_W-1:0] pbuf_q [EE_PAGE_BYTES];
  logic [EE_PAGE_BYTES-1:0] pvalid_q;
  logic [FW-1:0] flash_word_in_page_q;
  logic [FLASH_PTR_W-FW-2:0] flash_page_number_q;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  dmm_region_e rg;
  logic legal, eff_we, fire, nvm_fire, pend_d, page_end;
  logic [2:0] lat;
  logic [DATA_W-1:0] io_old, io_new, mask;
  logic grp_locked;
  logic [15:0] sram_off, ee_off;
  logic [DATA_W-1:0] sram_rd, ee_rd;
  logic ee_we;
  logic [EE_AW-1:0] ee_waddr, ee_raddr;
  logic [DATA_W-1:0] ee_wdata;

  always_comb begin
    rg = region_of(acc_addr_i, map_q);
    case (acc_kind_i)
      KIND_LDST: legal = 1'b1;
      KIND_SHORT_IO: legal = acc_addr_i <= SHORT_IO_LAST;
      KIND_SET_BIT, KIND_CLR_BIT, KIND_SKIP_SET, KIND_SKIP_CLR:
        legal = acc_addr_i <= BIT_IO_LAST;
      default: legal = 1'b0;
    endcase
    eff_we = ((acc_kind_i == KIND_LDST || acc_kind_i == KIND_SHORT_IO)
              && acc_we_i) || acc_kind_i == KIND_SET_BIT
              || acc_kind_i == KIND_CLR_BIT;
    if (acc_addr_i < GPR_COUNT) begin
      io_old = gpr_q[acc_addr_i[3:0]];
    end else begin
      case (acc_addr_i)
        ID_ADDR0: io_old = ID_BYTE0;
        ID_ADDR1: io_old = ID_BYTE1;
        ID_ADDR2: io_old = ID_BYTE2;
        REV_ADDR: io_old = REV_BYTE;
        default: io_old = periph_rdata_i;
      endcase
    end
    mask = BIT_ONE << acc_bit_i;
    case (acc_kind_i)
      KIND_SET_BIT: io_new = io_old | mask;
      KIND_CLR_BIT: io_new = io_old & ~mask;
      default: io_new = acc_wdata_i;
    endcase
    grp_locked = (lock_q[LOCK_CLK]
                  && in_range(acc_addr_i, CLK_GRP_FIRST, CLK_GRP_LAST))
              || (lock_q[LOCK_EVT]
                  && in_range(acc_addr_i, EVT_GRP_FIRST, EVT_GRP_LAST))
              || (lock_q[LOCK_WEX]
                  && in_range(acc_addr_i, WEX_GRP_FIRST, WEX_GRP_LAST));
    case (rg)
      RG_IO: lat = IO_CYC;
      RG_EE: lat = eff_we ? EE_LOAD_CYC :
                   (burst_q ? EE_BURST_CYC : EE_RD_CYC);
      RG_SRAM: lat = eff_we ? SRAM_WR_CYC : SRAM_RD_CYC;
      default: lat = RSVD_CYC;
    endcase
    if (!legal) begin
      lat = IO_CYC;
    end
  end

  assign fire = acc_req_i && ready_q;
  assign nvm_fire = nvm_req_i && st_q == ST_IDLE && !pend_q && !fire;
  assign page_end = st_q == ST_PAGE && idx_q == EE_BYTE_W'(EE_PAGE_BYTES - 1);
  assign pend_d = (fire && lat > LAT_SHORT)
               || (pend_q && cnt_q != 3'h0);
  assign sram_off = acc_addr_i - SRAM_BASE;
  assign ee_off = addr_q - EE_MAP_BASE;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (nvm_fire && (nvm_cmd_i == NVM_WR_PAGE
                         || nvm_cmd_i == NVM_ER_PAGE)) begin
          st_d = ST_PAGE;
        end
      ST_PAGE:
        if (page_end) begin
          st_d = ST_IDLE;
        end
      default: st_d = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage arrays

  logic [15:0] sram_roff;
  assign sram_roff = addr_q - SRAM_BASE;

  dmm_byte_mem #(.DEPTH(SRAM_BYTES), .AW(SRAM_AW)) u_sram (
    .clock_i(clock_i),
    .we_i(fire && legal && eff_we && rg == RG_SRAM),
    .waddr_i(sram_off[SRAM_AW-1:0]),
    .wdata_i(acc_wdata_i),
    .raddr_i(sram_roff[SRAM_AW-1:0]),
    .rdata_o(sram_rd)
  );

  always_comb begin
    ee_we = 1'b0;
    ee_waddr = nvm_addr_i;
    ee_wdata = ERASED_BYTE;
    if (st_q == ST_PAGE) begin
      ee_we = erase_q || pvalid_q[idx_q];
      ee_waddr = {page_q, idx_q};
      ee_wdata = erase_q ? ERASED_BYTE : pbuf_q[idx_q];
    end else if (nvm_fire && nvm_cmd_i == NVM_WR_BYTE) begin
      ee_we = pvalid_q[nvm_addr_i[EE_BYTE_W-1:0]];
      ee_wdata = pbuf_q[nvm_addr_i[EE_BYTE_W-1:0]];
    end else if (nvm_fire && nvm_cmd_i == NVM_ER_BYTE) begin
      ee_we = 1'b1;
    end
    ee_raddr = pend_q ? ee_off[EE_AW-1:0] : nvm_addr_i;
  end

  dmm_byte_mem #(.DEPTH(EE_BYTES), .AW(EE_AW)) u_eeprom (
    .clock_i(clock_i),
    .we_i(ee_we),
    .waddr_i(ee_waddr),
    .wdata_i(ee_wdata),
    .raddr_i(ee_raddr),
    .rdata_o(ee_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // CPU access sequencing

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      map_q <= 1'b0;
    end else begin
      map_q <= ee_map_en_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
      pend_q <= 1'b0;
      cnt_q <= 3'h0;
      addr_q <= 16'h0000;
      rg_q <= RG_IO;
      done_q <= 1'b0;
      rdata_q <= ZERO_BYTE;
      skip_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ready_q <= !pend_d && st_d == ST_IDLE;
      pend_q <= pend_d;
      done_q <= 1'b0;
      skip_q <= 1'b0;
      err_q <= 1'b0;
      if (fire) begin
        addr_q <= acc_addr_i;
        rg_q <= rg;
        cnt_q <= lat - LAT_OFFSET;
        if (!legal) begin
          done_q <= 1'b1;
          err_q <= 1'b1;
          rdata_q <= ZERO_BYTE;
        end else if (lat == LAT_SHORT) begin
          done_q <= 1'b1;
          rdata_q <= (rg == RG_IO && !eff_we) ? io_old : ZERO_BYTE;
          if (acc_kind_i == KIND_SKIP_SET) begin
            skip_q <= io_old[acc_bit_i];
          end else if (acc_kind_i == KIND_SKIP_CLR) begin
            skip_q <= !io_old[acc_bit_i];
          end
        end
      end else if (pend_q) begin
        if (cnt_q == 3'h0) begin
          done_q <= 1'b1;
          rdata_q <= (rg_q == RG_SRAM) ? sram_rd : ee_rd;
        end else begin
          cnt_q <= cnt_q - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_q <= 1'b0;
    end else begin
      burst_q <= pend_q && cnt_q == 3'h0 && rg_q == RG_EE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I/O space writes

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 16; i++) begin
        gpr_q[i] <= ZERO_BYTE;
      end
    end else if (fire && legal && eff_we && acc_addr_i < GPR_COUNT) begin
      gpr_q[acc_addr_i[3:0]] <= io_new;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwe_q <= 1'b0;
      blocked_q <= 1'b0;
      paddr_q <= 16'h0000;
      pwdata_q <= ZERO_BYTE;
    end else begin
      pwe_q <= fire && legal && eff_we && rg == RG_IO
               && acc_addr_i >= GPR_COUNT && !is_id(acc_addr_i)
               && !grp_locked;
      blocked_q <= fire && legal && eff_we && rg == RG_IO && grp_locked;
      if (fire) begin
        paddr_q <= acc_addr_i;
        pwdata_q <= io_new;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_q <= '0;
    end else if (lock_wr_i && ccp_open_i) begin
      lock_q <= lock_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // EEPROM page buffer and NVM commands

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pvalid_q <= '0;
      for (int i = 0; i < EE_PAGE_BYTES; i++) begin
        pbuf_q[i] <= ZERO_BYTE;
      end
    end else begin
      if (page_end || (nvm_fire && nvm_cmd_i == NVM_WR_BYTE)) begin
        pvalid_q <= '0;
      end
      if (fire && legal && eff_we && rg == RG_EE) begin
        pbuf_q[acc_addr_i[EE_BYTE_W-1:0]] <= acc_wdata_i;
        pvalid_q[acc_addr_i[EE_BYTE_W-1:0]] <= 1'b1;
      end else if (nvm_fire && nvm_cmd_i == NVM_LOAD_BUF) begin
        pbuf_q[nvm_addr_i[EE_BYTE_W-1:0]] <= nvm_wdata_i;
        pvalid_q[nvm_addr_i[EE_BYTE_W-1:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      idx_q <= '0;
      page_q <= '0;
      erase_q <= 1'b0;
      nbusy_q <= 1'b0;
      ndone_q <= 1'b0;
      nrdata_q <= ZERO_BYTE;
      ebyte_q <= '0;
      epage_q <= '0;
    end else begin
      st_q <= st_d;
      nbusy_q <= st_d == ST_PAGE;
      ndone_q <= page_end || (nvm_fire && st_d == ST_IDLE);
      idx_q <= (st_q == ST_PAGE) ? idx_q + 1'b1 : '0;
      if (nvm_fire) begin
        ebyte_q <= nvm_addr_i[EE_BYTE_W-1:0];
        epage_q <= nvm_addr_i[EE_AW-1:EE_BYTE_W];
        page_q <= nvm_addr_i[EE_AW-1:EE_BYTE_W];
        erase_q <= nvm_cmd_i == NVM_ER_PAGE;
        if (nvm_cmd_i == NVM_RD_BYTE) begin
          nrdata_q <= ee_rd;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_word_in_page_q <= '0;
      flash_page_number_q <= '0;
    end else begin
      flash_word_in_page_q <= flash_ptr_i[FW:1];
      flash_page_number_q <= flash_ptr_i[FLASH_PTR_W-1:FW+1];
    end
  end

  assign acc_ready_o = ready_q;
  assign acc_done_o = done_q;
  assign acc_rdata_o = rdata_q;
  assign acc_skip_o = skip_q;
  assign acc_err_o = err_q;
  assign periph_we_o = pwe_q;
  assign periph_addr_o = paddr_q;
  assign periph_wdata_o = pwdata_q;
  assign wr_blocked_o = blocked_q;
  assign lock_o = lock_q;
  assign nvm_busy_o = nbusy_q;
  assign nvm_done_o = ndone_q;
  assign nvm_rdata_o = nrdata_q;
  assign ee_byte_o = ebyte_q;
  assign ee_page_o = epage_q;
  assign flash_word_o = flash_word_in_page_q;
  assign flash_page_o = flash_page_number_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic rd_fire;
  assign rd_fire = fire && legal && !eff_we;

  property p_io_one;
    @(posedge clock_i) disable iff (!rst_n_i)
    fire && legal && rg == RG_IO |=> acc_done_o;
  endproperty
  a_io_one: assert property (p_io_one) else $error("io not one cycle");

  property p_sram_rd;
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_fire && rg == RG_SRAM |=> !acc_done_o ##1 acc_done_o;
  endproperty
  a_sram_rd: assert property (p_sram_rd) else $error("sram read late");

  property p_sram_wr;
    @(posedge clock_i) disable iff (!rst_n_i)
    fire && legal && eff_we && rg == RG_SRAM |=> acc_done_o && acc_ready_o;
  endproperty
  a_sram_wr: assert property (p_sram_wr) else $error("sram write late");

  property p_ee_rd;
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_fire && rg == RG_EE && !burst_q |=> !acc_done_o [*2] ##1 acc_done_o;
  endproperty
  a_ee_rd: assert property (p_ee_rd) else $error("ee read not 3");

  property p_ee_burst;
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_fire && rg == RG_EE && burst_q
      |=> !acc_done_o ##1 acc_done_o;
  endproperty
  a_ee_burst: assert property (p_ee_burst) else $error("burst gap");

  property p_unmapped;
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_fire && !map_q && in_range(acc_addr_i, EE_MAP_BASE, 16'h1FFF)
      |=> acc_done_o && acc_rdata_o == ZERO_BYTE;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("ee leaked");

  property p_rsvd;
    @(posedge clock_i) disable iff (!rst_n_i)
    fire && legal && rg == RG_RSVD
      |=> acc_done_o && acc_rdata_o == ZERO_BYTE && !periph_we_o;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved misread");

  property p_locked;
    @(posedge clock_i) disable iff (!rst_n_i)
    fire && legal && eff_we && rg == RG_IO && grp_locked
      |=> wr_blocked_o && !periph_we_o;
  endproperty
  a_locked: assert property (p_locked) else $error("locked write");

  property p_lock_ccp;
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(lock_o) |-> $past(ccp_open_i && lock_wr_i);
  endproperty
  a_lock_ccp: assert property (p_lock_ccp) else $error("lock w/o ccp");

  property p_bit_range;
    @(posedge clock_i) disable iff (!rst_n_i)
    fire && acc_kind_i == KIND_SET_BIT && acc_addr_i > BIT_IO_LAST
      |=> acc_err_o && !periph_we_o;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op range");

  property p_page_op;
    @(posedge clock_i) disable iff (!rst_n_i)
    nvm_fire && nvm_cmd_i == NVM_ER_PAGE |=> nvm_busy_o ##[31:33] nvm_done_o;
  endproperty
  a_page_op: assert property (p_page_op) else $error("page op length");

  c_ee_burst: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_fire && rg == RG_EE && burst_q);
  c_skip: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    acc_skip_o);
  c_blocked: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_blocked_o);
  c_page: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    page_end && !erase_q);

endmodule // dmm_data_access

// file: verif/dmm_periph_model.sv
`timescale 1ns/1ps
// Peripheral bank behind the I/O space; reads follow the address bus
module dmm_periph_model (
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [15:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [15:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [256];
  initial foreach (mem_q[i]) mem_q[i] = 8'hC3;
  always @(posedge clock_i) begin
    if (we_i) mem_q[waddr_i[7:0]] <= wdata_i;
  end
  assign rdata_o = mem_q[raddr_i[7:0]];
endmodule // dmm_periph_model

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dmm_pkg::*;
  logic clock_i = 0, rst_n_i = 0, acc_req_i = 0, acc_we_i = 0;
  dmm_kind_e acc_kind_i = KIND_LDST;
  logic [15:0] acc_addr_i = 16'h0000;
  logic [7:0] acc_wdata_i = 8'h00, periph_rdata_i, nvm_wdata_i = 8'h00;
  logic [2:0] acc_bit_i = 3'h0, lock_wdata_i = 3'h0, lock_o;
  logic acc_ready_o, acc_done_o, acc_skip_o, acc_err_o, periph_we_o;
  logic [7:0] acc_rdata_o, periph_wdata_o, nvm_rdata_o, flash_word_o;
  logic [15:0] periph_addr_o;
  logic wr_blocked_o, nvm_busy_o, nvm_done_o, nvm_req_i = 0;
  logic ee_map_en_i = 0, ccp_open_i = 0, lock_wr_i = 0;
  dmm_nvm_cmd_e nvm_cmd_i = NVM_NONE;
  logic [10:0] nvm_addr_i = 11'h000;
  logic [4:0] ee_byte_o;
  logic [5:0] ee_page_o;
  logic [23:0] flash_ptr_i = 24'h000000;
  logic [14:0] flash_page_o;
  int num_errors = 0, n_tests = 0, n;
  logic [7:0] rd;
  logic er, bl, sk, pw, bz;
  time t_low = 0;
  always #20 clock_i = ~clock_i;
  dmm_data_access DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .acc_req_i(acc_req_i), .acc_we_i(acc_we_i), .acc_kind_i(acc_kind_i),
    .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i),
    .acc_bit_i(acc_bit_i), .acc_ready_o(acc_ready_o),
    .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o),
    .acc_skip_o(acc_skip_o), .acc_err_o(acc_err_o),
    .ee_map_en_i(ee_map_en_i), .periph_rdata_i(periph_rdata_i),
    .periph_we_o(periph_we_o), .periph_addr_o(periph_addr_o),
    .periph_wdata_o(periph_wdata_o), .wr_blocked_o(wr_blocked_o),
    .ccp_open_i(ccp_open_i), .lock_wr_i(lock_wr_i),
    .lock_wdata_i(lock_wdata_i), .lock_o(lock_o), .nvm_req_i(nvm_req_i),
    .nvm_cmd_i(nvm_cmd_i), .nvm_addr_i(nvm_addr_i),
    .nvm_wdata_i(nvm_wdata_i), .nvm_busy_o(nvm_busy_o),
    .nvm_done_o(nvm_done_o), .nvm_rdata_o(nvm_rdata_o),
    .ee_byte_o(ee_byte_o), .ee_page_o(ee_page_o),
    .flash_ptr_i(flash_ptr_i), .flash_word_o(flash_word_o),
    .flash_page_o(flash_page_o));
  dmm_periph_model u_periph (.clock_i(clock_i), .we_i(periph_we_o),
    .waddr_i(periph_addr_o), .wdata_i(periph_wdata_o),
    .raddr_i(acc_addr_i), .rdata_o(periph_rdata_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bounded waits; a hang ends the run as a mismatch
  task automatic wait_done(ref logic s);
    // n counts cycles from the taking edge; single-cycle answers give 1
    n = 1;
    while (s !== 1'b1 && n < 40) begin @(posedge clock_i); #1 n++; end
    if (s !== 1'b1) begin num_errors++; tally_and_finish(); end
  endtask
  // Never lower and raise a strobe in one time step
  task automatic gap();
    if ($time == t_low) begin @(posedge clock_i); #1; end
  endtask
  task automatic acc(input dmm_kind_e k, input logic w, input logic [15:0] a,
      input logic [7:0] d);
    logic r;
    gap();
    acc_kind_i = k; acc_we_i = w; acc_addr_i = a; acc_wdata_i = d;
    acc_req_i = 1; n = 0;
    do begin r = acc_ready_o; @(posedge clock_i); n++; end
    while (r !== 1'b1 && n < 20);
    if (r !== 1'b1) begin num_errors++; tally_and_finish(); end
    #1 acc_req_i = 0;
    t_low = $time;
    wait_done(acc_done_o);
    rd = acc_rdata_o; er = acc_err_o; bl = wr_blocked_o;
    sk = acc_skip_o; pw = periph_we_o;
  endtask
  task automatic nvm(input dmm_nvm_cmd_e c, input logic [10:0] a);
    gap();
    nvm_cmd_i = c; nvm_addr_i = a; nvm_req_i = 1;
    @(posedge clock_i); #1 nvm_req_i = 0;
    t_low = $time;
    bz = nvm_busy_o;
    wait_done(nvm_done_o);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_mem();
    acc(KIND_LDST, 1, 16'h2010, 8'hA5); chk("sram wr cyc", 1, n);
    acc(KIND_LDST, 0, 16'h2010, 8'h00); chk("sram rd cyc", 2, n);
    chk("sram data", 8'hA5, rd);
    acc(KIND_LDST, 1, 16'h0200, 8'h3C); chk("io wr cyc", 1, n);
    chk("io pwe", 1, pw);
    acc(KIND_LDST, 0, 16'h0200, 8'h00); chk("io rd", 8'h3C, rd);
    acc(KIND_LDST, 1, 16'h0005, 8'h77);
    acc(KIND_LDST, 0, 16'h0005, 8'h00); chk("gp reg", 8'h77, rd);
    $display("test mem done");
  endtask
  task automatic t_kinds();
    acc(KIND_SHORT_IO, 0, 16'h0040, 8'h00); chk("short 40", 1, er);
    acc(KIND_SHORT_IO, 0, 16'h003F, 8'h00); chk("short 3F", 0, er);
    acc(KIND_SET_BIT, 0, 16'h0020, 8'h00); chk("bit 20", 1, er);
    acc(KIND_CLR_BIT, 0, 16'h0005, 8'h00); chk("bit 05", 0, er);
    acc(KIND_LDST, 0, 16'h0005, 8'h00); chk("bit clr", 8'h76, rd);
    acc_bit_i = 3'h1;
    acc(KIND_SKIP_SET, 0, 16'h0005, 8'h00); chk("skip set", 1, sk);
    acc(KIND_SKIP_CLR, 0, 16'h0005, 8'h00); chk("skip clr", 0, sk);
    acc_bit_i = 3'h0;
    acc(KIND_SET_BIT, 0, 16'h0005, 8'h00); chk("set err", 0, er);
    acc(KIND_LDST, 0, 16'h0005, 8'h00); chk("bit set", 8'h77, rd);
    $display("test kinds done");
  endtask
  task automatic t_lock();
    lock_wdata_i = 3'h1; lock_wr_i = 1;
    @(posedge clock_i); #1 chk("lock closed", 0, lock_o);
    ccp_open_i = 1;
    @(posedge clock_i); #1 chk("lock open", 1, lock_o);
    lock_wr_i = 0; ccp_open_i = 0;
    acc(KIND_LDST, 1, 16'h0050, 8'h12); chk("locked wr", 1, bl);
    chk("locked pwe", 0, pw);
    $display("test lock done");
  endtask
  task automatic t_ee();
    acc(KIND_LDST, 0, 16'h1000, 8'h00); chk("unmapped", 0, rd);
    ee_map_en_i = 1;
    repeat (2) @(posedge clock_i);
    #1 acc(KIND_LDST, 0, 16'h1000, 8'h00); chk("ee rd cyc", 3, n);
    acc(KIND_LDST, 1, 16'h1004, 8'h5E); chk("ee ld cyc", 1, n);
    acc(KIND_LDST, 0, 16'h1900, 8'h00); chk("rsvd", 0, rd);
    chk("rsvd cyc", 1, n);
    nvm(NVM_WR_PAGE, 11'h000); chk("page busy", 1, bz);
    chk("page cyc", 33, n);
    chk("page idle", 0, nvm_busy_o);
    acc(KIND_LDST, 0, 16'h1004, 8'h00); chk("ee data", 8'h5E, rd);
    acc(KIND_LDST, 0, 16'h1004, 8'h00); chk("burst cyc", 2, n);
    chk("burst data", 8'h5E, rd);
    nvm(NVM_RD_BYTE, 11'h004); chk("nvm rd", 8'h5E, nvm_rdata_o);
    $display("test ee done");
  endtask
  task automatic t_misc();
    acc(KIND_LDST, 1, 16'h0090, 8'h00); chk("id pwe", 0, pw);
    acc(KIND_LDST, 0, 16'h0090, 8'h00); chk("id", 8'h5A, rd);
    flash_ptr_i = 24'h00ABCD;
    nvm(NVM_RD_BYTE, 11'h3A5); chk("nvm cyc", 1, n);
    chk("ee byte", 5'h05, ee_byte_o);
    chk("ee page", 6'h1D, ee_page_o);
    chk("fl word", 8'hE6, flash_word_o);
    chk("fl page", 15'h0055, flash_page_o);
    $display("test misc done");
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    #1 rst_n_i = 1;
    repeat (2) @(posedge clock_i);
    #1 t_mem();
    t_kinds();
    t_lock();
    t_ee();
    t_misc();
    tally_and_finish();
  end
endmodule // testbench
